// File: acpi_setup_command_port.sv
// setup command port: apb registers, input and irq mapping, atomic i/o list
// assumes a 20 MHz clk_sys, memory and i/o slaves that answer with acks
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "acpi_setup_defines.svh"

// Functional notes
// - enabled event status bit set raises the system control interrupt.
// - indexes 0x10-0x17 map inputs 0-7 onto a status bit.
// - indexes 0x30-0x3F configure wake on irq lines 0-15.
// - index 0x40 sets the global flag and raises the interrupt.
// - mapping byte 0x00 none, 0x08 power, 0x09 sleep, 0x10-0x1F events.
// - edge nibble: 0x01 falling, 0x02 rising, 0x04 power button; the 0x04 bit is not used.
// - mapping word holds zero, wake nibble, edge nibble, target byte.
// - input 6 may signal an event on both edges.
// - irq wake data 0 off, 0x0a pm bit 10, 0x10-0x1F events.
// - irq wake status sets only while sleeping and the line rises.
// - wake only when the set status bit is also enabled.
// - irq 8 defaults to the clock alarm flag; host leaves it.
// - 0x41 picks sci irq 3-7, 9-12, 14-15; others ignored.
// - sci irq is 9 after reset.
// - fixed registers read as zero until 0x42 has been issued.
// - 0x43 runs the list at the argument address without interleaving.
// - list is one header followed by one or more operation blocks.
// - header four words; block four bytes and three words.
// - 0x50 turns video power off on 0, on on 1.
// - 0x60 onward emulate soft smi codes 0x6000 onward; only 0x60-0x63 are decoded.
// - block op byte: 1 read, 2 write, 3 and-or, 4 define ports.
// - block size byte: 1 byte, 2 word, 3 double word.
module acpi_setup_command_port
  import acpi_setup_pkg::*;
(
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // external event sources
  input  wire logic [7:0]  general_input_n,
  input  wire logic [15:0] irq_line,
  // system signals
  output logic             sci_out,
  output logic [3:0]       sci_irq,
  output logic             wake_out,
  output logic             video_power,
  output logic             smi_pulse,
  output logic [15:0]      smi_code,
  output logic [31:0]      smi_arg,
  // memory master for the atomic list
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  // i/o master, locked for a whole list
  output logic             io_req,
  output logic             io_we,
  output logic             io_lock,
  output logic [15:0]      io_addr,
  output logic [1:0]       io_size,
  output logic [31:0]      io_wdata,
  input  wire logic        io_ack,
  input  wire logic [31:0] io_rdata
);

  // event mask of a target byte in 0x10..0x1F
  function automatic logic [15:0] event_mask(input logic [7:0] tgt);
    event_mask = 16'h0000;
    if (tgt[7:4] == `TGT_EVENT_HI) event_mask[tgt[3:0]] = 1'b1;
  endfunction

  // pm status mask of a target byte
  function automatic logic [15:0] pm_mask(input logic [7:0] tgt);
    pm_mask = 16'h0000;
    if (tgt == `TGT_PWR_BUTTON) pm_mask[`PM_PWR_BUTTON] = 1'b1;
    if (tgt == `TGT_SLP_BUTTON) pm_mask[`PM_SLP_BUTTON] = 1'b1;
    if (tgt == `TGT_RTC)        pm_mask[`PM_RTC] = 1'b1;
  endfunction

  // data mask for an access size
  function automatic logic [31:0] size_mask(input logic [7:0] sz);
    if (sz == `SIZE_BYTE)      size_mask = 32'h0000_00FF;
    else if (sz == `SIZE_WORD) size_mask = 32'h0000_FFFF;
    else                       size_mask = 32'hFFFF_FFFF;
  endfunction

  // sci irq numbers that may be selected
  function automatic logic sci_valid(input logic [31:0] v);
    sci_valid = (v >= 32'd3 && v <= 32'd7) || (v >= 32'd9 && v <= 32'd12)
             || (v == 32'd14) || (v == 32'd15);
  endfunction

  logic [31:0] setup_arg_reg;
  logic [15:0] evt_status_reg;
  logic [15:0] evt_enable_reg;
  logic [15:0] pm_status_reg;
  logic [3:0]  sci_irq_reg;
  logic        read_unlock_reg;
  logic        video_reg;
  logic        sleep_reg;
  logic        seq_err_reg;
  logic [7:0]  gpio_tgt_reg [8];
  logic [3:0]  gpio_edge_reg [8];
  logic [3:0]  gpio_wake_reg [8];
  logic [7:0]  irq_tgt_reg [16];
  logic [23:0] in_sync_reg [3];
  logic [23:0] in_level_reg;
  logic [23:0] rise;
  logic [23:0] fall;
  logic [15:0] evt_set;
  logic [15:0] pm_set;
  logic        wr;
  logic        rd;
  logic        cmd_wr;
  logic [7:0]  cmd;
  seq_state_t  state_reg;
  logic        busy;

  // apb strobes; single-cycle answer
  assign pready  = 1'b1;
  assign wr      = psel && penable && pwrite;
  assign rd      = psel && penable && !pwrite;
  assign cmd     = pwdata[7:0];
  assign busy    = (state_reg != ST_IDLE);
  assign cmd_wr  = wr && (paddr == `ADDR_CMD_INDEX) && !busy;

  // bus error for unmapped addresses or a command during a list
  always_comb begin
    pslverr = 1'b0;
    if (psel && penable) begin
      if (paddr > `ADDR_RSVD_HI || paddr[1:0] != 2'b00) pslverr = 1'b1;
      if (wr && paddr == `ADDR_CMD_INDEX && busy) pslverr = 1'b1;
    end
  end

  // read mux; fixed registers hidden until unlocked
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd) begin
      unique case (paddr)
        `ADDR_EVT_STATUS: if (read_unlock_reg) prdata = {16'h0, evt_status_reg};
        `ADDR_EVT_ENABLE: if (read_unlock_reg) prdata = {16'h0, evt_enable_reg};
        `ADDR_PM_STATUS:  if (read_unlock_reg) prdata = {16'h0, pm_status_reg};
        `ADDR_CONTROL:    prdata = {23'h0, sci_irq_reg, busy, seq_err_reg,
                                    read_unlock_reg, video_reg, sleep_reg};
        `ADDR_SETUP_ARG:  prdata = setup_arg_reg;
        default:          prdata = 32'h0000_0000;
      endcase
    end
  end

  // argument, enable and sleep control writes
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      setup_arg_reg  <= `RESET_SETUP_ARG;
      evt_enable_reg <= 16'h0000;
      sleep_reg      <= 1'b0;
    end else if (wr) begin
      if (paddr == `ADDR_SETUP_ARG) setup_arg_reg <= pwdata;
      if (paddr == `ADDR_EVT_ENABLE) evt_enable_reg <= pwdata[15:0];
      if (paddr == `ADDR_CONTROL) sleep_reg <= pwdata[`CTRL_SLEEP];
    end
  end

  // three-stage input sampling; a level counts once stages two and three agree
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      in_sync_reg[0] <= 24'h000000;
      in_sync_reg[1] <= 24'h000000;
      in_sync_reg[2] <= 24'h000000;
      in_level_reg   <= 24'h000000;
    end else begin
      in_sync_reg[0] <= {irq_line, general_input_n};
      in_sync_reg[1] <= in_sync_reg[0];
      in_sync_reg[2] <= in_sync_reg[1];
      in_level_reg   <= (in_sync_reg[1] & in_sync_reg[2])
                      | (in_level_reg & (in_sync_reg[1] | in_sync_reg[2]));
    end
  end

  assign rise = in_sync_reg[2] & ~in_level_reg & in_sync_reg[1];
  assign fall = ~in_sync_reg[2] & in_level_reg & ~in_sync_reg[1];

  // input and irq mapping tables
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < 8; i++) begin
        gpio_tgt_reg[i]  <= `TGT_NONE;
        gpio_edge_reg[i] <= 4'h0;
        gpio_wake_reg[i] <= 4'h0;
      end
      for (int i = 0; i < 16; i++) irq_tgt_reg[i] <= `TGT_NONE;
      irq_tgt_reg[8] <= `TGT_RTC;
    end else if (cmd_wr) begin
      if (cmd >= `CMD_GPIO_FIRST && cmd <= `CMD_GPIO_LAST) begin
        gpio_tgt_reg[cmd[2:0]]  <= setup_arg_reg[7:0];
        gpio_edge_reg[cmd[2:0]] <= setup_arg_reg[11:8];
        gpio_wake_reg[cmd[2:0]] <= setup_arg_reg[15:12];
      end
      if (cmd >= `CMD_IRQ_FIRST && cmd <= `CMD_IRQ_LAST) begin
        irq_tgt_reg[cmd[3:0]] <= setup_arg_reg[7:0];
      end
    end
  end

  // events from mapped inputs and sleeping irq activity
  always_comb begin
    evt_set = 16'h0000;
    pm_set  = 16'h0000;
    for (int i = 0; i < 8; i++) begin
      // every input, 6 included, may fire on either or both edges
      if ((gpio_edge_reg[i][`EDGE_RISE] && rise[i]) ||
          (gpio_edge_reg[i][`EDGE_FALL] && fall[i])) begin
        evt_set = evt_set | event_mask(gpio_tgt_reg[i]);
        pm_set  = pm_set | pm_mask(gpio_tgt_reg[i]);
      end
    end
    for (int i = 0; i < 16; i++) begin
      if (sleep_reg && rise[8 + i]) begin
        evt_set = evt_set | event_mask(irq_tgt_reg[i]);
        pm_set  = pm_set | pm_mask(irq_tgt_reg[i]);
      end
    end
    if (cmd_wr && cmd == `CMD_GLOBAL) pm_set[`PM_GLOBAL] = 1'b1;
  end

  // sticky status; a set in the clearing cycle wins
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      evt_status_reg <= 16'h0000;
      pm_status_reg  <= 16'h0000;
    end else begin
      evt_status_reg <= (evt_status_reg & ~((wr && paddr == `ADDR_EVT_STATUS)
                        ? pwdata[15:0] : 16'h0000)) | evt_set;
      pm_status_reg  <= (pm_status_reg & ~((wr && paddr == `ADDR_PM_STATUS)
                        ? pwdata[15:0] : 16'h0000)) | pm_set;
    end
  end

  // interrupt and wake outputs
  assign sci_out  = (|(evt_status_reg & evt_enable_reg))
                  | pm_status_reg[`PM_GLOBAL];
  assign wake_out = sleep_reg && (|(evt_status_reg & evt_enable_reg));
  assign sci_irq  = sci_irq_reg;
  assign video_power = video_reg;

  // simple commands; unassigned indexes leave state alone
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sci_irq_reg     <= `SCI_IRQ_RESET;
      read_unlock_reg <= 1'b0;
      video_reg       <= 1'b0;
      smi_pulse       <= 1'b0;
      smi_code        <= 16'h0000;
      smi_arg         <= 32'h0000_0000;
    end else begin
      smi_pulse <= 1'b0;
      if (cmd_wr) begin
        if (cmd == `CMD_SCI_SELECT && sci_valid(setup_arg_reg))
          sci_irq_reg <= setup_arg_reg[3:0];
        if (cmd == `CMD_READ_UNLOCK) read_unlock_reg <= 1'b1;
        if (cmd == `CMD_VIDEO_POWER && setup_arg_reg[31:1] == 31'h0)
          video_reg <= setup_arg_reg[0];
        if (cmd >= `CMD_SMI_FIRST && cmd <= `CMD_SMI_LAST) begin
          smi_pulse <= 1'b1;
          smi_code  <= `SMI_CODE_BASE + {14'h0, cmd[1:0]};
          smi_arg   <= setup_arg_reg;
        end
      end
    end
  end

  // atomic list sequencer registers
  logic [31:0] seq_base_reg;
  logic [31:0] seq_len_reg;
  logic [31:0] seq_off_reg;
  logic [1:0]  word_reg;
  logic        hdr_reg;
  logic [7:0]  op_reg;
  logic [7:0]  size_reg;
  logic [31:0] addr_reg;
  logic [31:0] data_reg;
  logic [31:0] or_reg;
  logic [15:0] idx_port_reg;
  logic [15:0] dat_port_reg;
  logic [7:0]  idx_size_reg;
  logic [31:0] result_reg;
  logic        seq_more;
  logic [15:0] op_port;

  assign seq_more = (seq_off_reg < seq_len_reg);
  assign op_port  = op_reg[`OP_INDEX_BIT] ? dat_port_reg : addr_reg[15:0];

  // list walk: header, then blocks until the length is used up
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      seq_base_reg <= 32'h0; seq_len_reg <= 32'h0; seq_off_reg <= 32'h0;
      word_reg <= 2'd0; hdr_reg <= 1'b0; op_reg <= 8'h0; size_reg <= 8'h0;
      addr_reg <= 32'h0; data_reg <= 32'h0; or_reg <= 32'h0;
      idx_port_reg <= 16'h0; dat_port_reg <= 16'h0; idx_size_reg <= 8'h0;
      result_reg <= 32'h0; seq_err_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: if (cmd_wr && cmd == `CMD_ATOMIC_IO) begin
          seq_base_reg <= setup_arg_reg;
          seq_off_reg  <= 32'h0;
          seq_len_reg  <= `LIST_HDR_BYTES;
          word_reg     <= 2'd0;
          hdr_reg      <= 1'b1;
          seq_err_reg  <= 1'b0;
          state_reg    <= ST_FETCH;
        end
        ST_FETCH: if (mem_ack) begin
          word_reg <= word_reg + 2'd1;
          if (hdr_reg) begin
            if (word_reg == 2'd0 && mem_rdata != `LIST_SIGNATURE) begin
              seq_err_reg <= 1'b1;
              state_reg   <= ST_IDLE;
            end
            if (word_reg == 2'd1) seq_len_reg <= mem_rdata;
          end else begin
            if (word_reg == 2'd0) begin
              op_reg   <= mem_rdata[7:0];
              size_reg <= mem_rdata[23:16];
            end
            if (word_reg == 2'd1) addr_reg <= mem_rdata;
            if (word_reg == 2'd2) data_reg <= mem_rdata;
            if (word_reg == 2'd3) or_reg <= mem_rdata;
          end
          if (word_reg == 2'd3) begin
            seq_off_reg <= seq_off_reg + `LIST_HDR_BYTES;
            hdr_reg     <= 1'b0;
            state_reg   <= (seq_off_reg + `LIST_HDR_BYTES < seq_len_reg)
                         ? ST_FETCH : ST_IDLE;
            if (!hdr_reg && !op_reg[`OP_NOOP_BIT]) begin
              if (op_reg[5:0] == `OP_DEFINE) begin
                idx_port_reg <= addr_reg[15:0];
                dat_port_reg <= data_reg[15:0];
                idx_size_reg <= size_reg;
              end else if (op_reg[`OP_INDEX_BIT]) begin
                state_reg <= ST_INDEX;
              end else if (op_reg[5:0] == `OP_WRITE) begin
                state_reg <= ST_WRITE;
              end else if (op_reg[5:0] == `OP_READ ||
                           op_reg[5:0] == `OP_RMW) begin
                state_reg <= ST_READ;
              end
            end
          end
        end
        ST_INDEX: if (io_ack) begin
          state_reg <= (op_reg[5:0] == `OP_WRITE) ? ST_WRITE : ST_READ;
        end
        ST_READ: if (io_ack) begin
          result_reg <= io_rdata & size_mask(size_reg);
          data_reg   <= ((io_rdata & data_reg) | or_reg) & size_mask(size_reg);
          state_reg  <= (op_reg[5:0] == `OP_RMW) ? ST_WRITE : ST_STORE;
        end
        ST_WRITE: if (io_ack) state_reg <= seq_more ? ST_FETCH : ST_IDLE;
        ST_STORE: if (mem_ack) state_reg <= seq_more ? ST_FETCH : ST_IDLE;
      endcase
    end
  end

  // master requests; the i/o lock spans the whole list
  assign mem_req   = (state_reg == ST_FETCH) || (state_reg == ST_STORE);
  assign mem_we    = (state_reg == ST_STORE);
  assign mem_addr  = (state_reg == ST_STORE)
                   ? seq_base_reg + seq_off_reg - `LIST_HDR_BYTES
                     + `BLK_DATA_OFS
                   : seq_base_reg + seq_off_reg + {28'h0, word_reg, 2'b00};
  assign mem_wdata = result_reg;
  assign io_lock   = busy;
  assign io_req    = (state_reg == ST_INDEX) || (state_reg == ST_READ)
                   || (state_reg == ST_WRITE);
  assign io_we     = (state_reg == ST_INDEX) || (state_reg == ST_WRITE);
  assign io_addr   = (state_reg == ST_INDEX) ? idx_port_reg : op_port;
  assign io_size   = (state_reg == ST_INDEX) ? idx_size_reg[1:0]
                                             : size_reg[1:0];
  assign io_wdata  = (state_reg == ST_INDEX)
                   ? addr_reg & size_mask(idx_size_reg)
                   : data_reg & size_mask(size_reg);

endmodule
`default_nettype wire

// File: acpi_setup_defines.svh
// constants for the power-management setup command port
// assumes inclusion by bare name from the design files
`ifndef ACPI_SETUP_DEFINES_SVH
`define ACPI_SETUP_DEFINES_SVH

// apb byte addresses
`define ADDR_CMD_INDEX   12'h000
`define ADDR_EVT_STATUS  12'h004
`define ADDR_EVT_ENABLE  12'h008
`define ADDR_PM_STATUS   12'h00C
`define ADDR_CONTROL     12'h010
`define ADDR_SETUP_ARG   12'h014
`define ADDR_RSVD_LO     12'h018
`define ADDR_RSVD_HI     12'h01C
`define RESET_SETUP_ARG  32'h0000_0000

// command indexes
`define CMD_NOP          8'h00
`define CMD_GPIO_FIRST   8'h10
`define CMD_GPIO_LAST    8'h17
`define CMD_IRQ_FIRST    8'h30
`define CMD_IRQ_LAST     8'h3F
`define CMD_GLOBAL       8'h40
`define CMD_SCI_SELECT   8'h41
`define CMD_READ_UNLOCK  8'h42
`define CMD_ATOMIC_IO    8'h43
`define CMD_VIDEO_POWER  8'h50
`define CMD_SMI_FIRST    8'h60
`define CMD_SMI_LAST     8'h63
`define SMI_CODE_BASE    16'h6000

// mapping targets
`define TGT_NONE         8'h00
`define TGT_PWR_BUTTON   8'h08
`define TGT_SLP_BUTTON   8'h09
`define TGT_RTC          8'h0A
`define TGT_EVENT_HI     4'h1
`define EDGE_FALL        0
`define EDGE_RISE        1
`define EDGE_PWRBTN      2

// pm status bit positions
`define PM_GLOBAL        5
`define PM_PWR_BUTTON    8
`define PM_SLP_BUTTON    9
`define PM_RTC           10
`define SCI_IRQ_RESET    4'd9
`define CTRL_SLEEP       0

// atomic list layout
`define LIST_SIGNATURE   32'h0000_0070
`define LIST_HDR_BYTES   32'h0000_0010
`define BLK_DATA_OFS     32'h0000_0008
`define OP_READ          6'h01
`define OP_WRITE         6'h02
`define OP_RMW           6'h03
`define OP_DEFINE        6'h04
`define OP_NOOP_BIT      7
`define OP_INDEX_BIT     6
`define SIZE_BYTE        8'h01
`define SIZE_WORD        8'h02

`endif

// File: acpi_setup_pkg.sv
// types shared by the setup command port
// assumes nothing beyond a systemverilog compiler
package acpi_setup_pkg;
  typedef enum logic [5:0] {
    ST_IDLE  = 6'b000001,
    ST_FETCH = 6'b000010,
    ST_INDEX = 6'b000100,
    ST_READ  = 6'b001000,
    ST_WRITE = 6'b010000,
    ST_STORE = 6'b100000
  } seq_state_t;
endpackage

// File: setup_io_partner.sv
// memory and i/o responder standing behind the atomic list masters
// assumes one request at a time, held by the port until acknowledged
`timescale 1ns/100ps
`default_nettype none
module setup_io_partner (
  // clock, reset and answer delay in cycles
  input  wire logic        clk_sys, rstn,
  input  wire logic [3:0]  slow,
  // memory slave
  input  wire logic        mem_req, mem_we,
  input  wire logic [31:0] mem_addr, mem_wdata,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata,
  // i/o slave
  input  wire logic        io_req, io_we,
  input  wire logic [15:0] io_addr,
  input  wire logic [1:0]  io_size,
  input  wire logic [31:0] io_wdata,
  output logic             io_ack,
  output logic [31:0]      io_rdata
);
  localparam logic [31:0] IO_VALUE = 32'hCAFE_F00D;
  logic [31:0] mem [256];
  logic [15:0] wr_addr [4];
  logic [31:0] wr_data [4];
  logic [1:0]  wr_size [4];
  logic [2:0]  wr_cnt;
  logic [3:0]  cnt;
  // answers after the set delay; data lines toggle while not answering
  always @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      {cnt, wr_cnt, mem_ack, io_ack, mem_rdata, io_rdata} <= '0;
    end else begin
      mem_ack <= 1'b0;
      io_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      io_rdata <= ~io_rdata;
      if ((mem_req || io_req) && !mem_ack && !io_ack) begin
        cnt <= cnt + 4'h1;
        if (cnt >= slow) begin
          cnt <= 4'h0;
          mem_ack <= mem_req;
          io_ack <= !mem_req;
          if (mem_req && mem_we)
            mem[mem_addr[9:2]] <= mem_wdata;
          if (mem_req && !mem_we)
            mem_rdata <= mem[mem_addr[9:2]];
          if (!mem_req && !io_we)
            io_rdata <= IO_VALUE;
          if (!mem_req && io_we) begin
            wr_addr[wr_cnt[1:0]] <= io_addr;
            wr_data[wr_cnt[1:0]] <= io_wdata;
            wr_size[wr_cnt[1:0]] <= io_size;
            wr_cnt <= wr_cnt + 3'h1;
          end
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: setup_port_asserts.sv
// checker for the setup command port, fed from its top-level ports
// assumes the port names and widths of acpi_setup_command_port
`timescale 1ns/100ps
`default_nettype none
`include "acpi_setup_defines.svh"
module setup_port_asserts (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rstn,
  // apb slave side
  input wire logic        psel, penable, pwrite, pslverr,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  // system and i/o outputs, with the i/o acknowledge input
  input wire logic        sci_out, smi_pulse, io_req, io_lock, io_ack,
  input wire logic [3:0]  sci_irq,
  input wire logic [15:0] io_addr
);
  logic       idx_hit;
  logic       sel_wr;
  logic       unl_reg;
  logic [7:0] idx;
  // index writes decoded in the access phase
  assign idx = pwdata[7:0];
  assign idx_hit = psel && penable && pwrite && paddr == `ADDR_CMD_INDEX;
  assign sel_wr = idx_hit && idx == `CMD_SCI_SELECT && !io_lock;
  // remembers whether reads of the fixed registers were opened
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn)
      unl_reg <= 1'b0;
    else if (idx_hit && idx == `CMD_READ_UNLOCK && !io_lock)
      unl_reg <= 1'b1;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence glob_s; idx_hit && idx == `CMD_GLOBAL && !io_lock; endsequence
  sequence smi_s; idx_hit && idx[7:2] == 6'h18 && !io_lock; endsequence
  sequence hid_s; psel && penable && !pwrite && !unl_reg &&
    paddr inside {`ADDR_EVT_STATUS, `ADDR_EVT_ENABLE, `ADDR_PM_STATUS};
  endsequence
  AST_GLOBAL_SCI: assert property (glob_s |-> ##[1:3] sci_out)
    else $error("sci not raised by global command");
  AST_IRQ_LEGAL: assert property (sci_irq inside
    {[4'h3:4'h7], [4'h9:4'hC], 4'hE, 4'hF}) else $error("illegal sci irq");
  AST_IRQ_CAUSE: assert property ($changed(sci_irq)
    |-> $past(sel_wr) || $past(sel_wr, 2)) else $error("sci irq moved");
  AST_FIXED_HIDDEN: assert property (hid_s |-> prdata == 32'h0)
    else $error("fixed register readable before unlock");
  AST_LOCK_COVERS_IO: assert property (io_req |-> io_lock)
    else $error("i/o access outside lock");
  AST_BUSY_REFUSE: assert property (idx_hit && io_lock |-> pslverr)
    else $error("index write accepted while busy");
  AST_IO_HOLD: assert property (io_req && !io_ack
    |=> io_req && $stable(io_addr)) else $error("i/o request dropped");
  AST_SMI_AFTER_CMD: assert property (smi_s |-> ##[1:3] smi_pulse)
    else $error("no smi pulse after command");
  AST_SMI_ONE: assert property (smi_pulse |=> !smi_pulse)
    else $error("smi pulse too long");
endmodule
bind acpi_setup_command_port setup_port_asserts u_setup_port_asserts (.*);
`default_nettype wire

// File: tb.sv
// self-checking bench for the setup command port over apb
// assumes the responder model behind the list masters
`timescale 1ns/100ps
`default_nettype none
`include "acpi_setup_defines.svh"
module tb;
  logic        clk_sys, rstn, psel, penable, pwrite, pready, pslverr, err;
  logic        sci_out, wake_out, video_power, smi_pulse, mem_req, mem_we;
  logic        mem_ack, io_req, io_we, io_lock, io_ack;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, smi_arg, mem_addr, mem_wdata, mem_rdata;
  logic [31:0] io_wdata, io_rdata;
  logic [31:0] lst [16];
  logic [15:0] irq_line, smi_code, io_addr;
  logic [7:0]  general_input_n;
  logic [3:0]  sci_irq, exp_irq, slow;
  logic [1:0]  io_size;
  int          fail_count, checked, i;
  // design and the responder behind it
  acpi_setup_command_port u_acpi_setup_command_port (.*);
  setup_io_partner u_setup_io_partner (.*);
  // 20 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  // compares and counts
  task automatic chk(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer; data and error taken at the pready edge
  task automatic apb(input logic w, input logic [11:0] a, logic [31:0] d);
    @(posedge clk_sys);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic rdchk(input string n, input logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask
  // argument first, then the index that runs it
  task automatic cmd(input logic [7:0] idx, input logic [31:0] arg);
    apb(1'b1, `ADDR_SETUP_ARG, arg);
    apb(1'b1, `ADDR_CMD_INDEX, {24'h0, idx});
    repeat (3) @(posedge clk_sys);
  endtask
  // counts and verdict
  task automatic stop_test;
    $display("fail_count %0d checked %0d", fail_count, checked);
    if (fail_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // watchdog well above the sequence length
  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    stop_test;
  end
  // test sequence
  initial begin
    {rstn, psel, penable, pwrite, paddr, pwdata, slow} = '0;
    {general_input_n, irq_line, fail_count, checked} = '0;
    lst = '{32'h70, 32'h40, 32'h0, 32'h0, 32'h1_0002, 32'h2E, 32'h5A,
      32'h0, 32'h3_0001, 32'h2F, 32'h0, 32'h0, 32'h3_0003, 32'h2F,
      32'hFFFF_0000, 32'h1234};
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    chk("sci_irq", sci_irq, 32'h9);
    rdchk("arg", `ADDR_SETUP_ARG, 32'h0);
    apb(1'b1, `ADDR_EVT_ENABLE, 32'hFFFF);
    rdchk("en", `ADDR_EVT_ENABLE, 32'h0);
    cmd(`CMD_READ_UNLOCK, 32'h0);
    rdchk("en", `ADDR_EVT_ENABLE, 32'hFFFF);
    cmd(`CMD_NOP, 32'h1);
    cmd(8'h20, 32'h1);
    chk("nop", {video_power, sci_irq}, 32'h9);
    exp_irq = 4'h9;
    for (i = 0; i < 16; i++) begin
      cmd(`CMD_SCI_SELECT, i);
      if (i inside {[3:7], [9:12], 14, 15}) exp_irq = i[3:0];
      chk("sci_irq", sci_irq, exp_irq);
    end
    apb(1'b0, `ADDR_CONTROL, 32'h0);
    chk("ctl", rd & 32'h1E1, 32'h1E0);
    for (i = 0; i < 3; i++) begin
      cmd(`CMD_VIDEO_POWER, (32'h1 << i) & 32'h3);
      chk("video", video_power, i < 2);
    end
    for (i = 0; i < 4; i++) begin
      cmd(`CMD_SMI_FIRST + i[7:0], 32'hA5A5_0000 + i);
      chk("smi", {smi_code, smi_arg[15:0]}, {16'h6000 + i[15:0], i[15:0]});
    end
    cmd(`CMD_GLOBAL, 32'h0);
    chk("sci", sci_out, 32'h1);
    rdchk("pm", `ADDR_PM_STATUS, 32'h20);
    cmd(8'h13, 32'h0213);
    cmd(8'h16, 32'h0315);
    cmd(8'h11, 32'h0608);
    general_input_n <= 8'h4A;
    repeat (8) @(posedge clk_sys);
    rdchk("evt", `ADDR_EVT_STATUS, 32'h28);
    rdchk("pm", `ADDR_PM_STATUS, 32'h120);
    apb(1'b1, `ADDR_PM_STATUS, 32'h120);
    apb(1'b1, `ADDR_EVT_ENABLE, 32'hFFD7);
    repeat (2) @(posedge clk_sys);
    chk("sci", sci_out, 32'h0);
    apb(1'b1, `ADDR_EVT_STATUS, 32'h28);
    general_input_n <= 8'h02;
    repeat (8) @(posedge clk_sys);
    rdchk("evt", `ADDR_EVT_STATUS, 32'h20);
    apb(1'b1, `ADDR_EVT_STATUS, 32'h20);
    cmd(8'h34, 32'h14);
    for (i = 0; i < 2; i++) begin
      apb(1'b1, `ADDR_CONTROL, i);
      irq_line <= 16'h0110;
      repeat (8) @(posedge clk_sys);
      irq_line <= 16'h0;
      repeat (8) @(posedge clk_sys);
      rdchk("evt", `ADDR_EVT_STATUS, 32'h10 * i);
      rdchk("pm", `ADDR_PM_STATUS, 32'h400 * i);
    end
    chk("wake", wake_out, 32'h1);
    chk("sci", sci_out, 32'h1);
    apb(1'b1, `ADDR_EVT_ENABLE, 32'h0);
    repeat (2) @(posedge clk_sys);
    chk("wake", wake_out, 32'h0);
    for (i = 0; i < 16; i++) u_setup_io_partner.mem[64 + i] = lst[i];
    slow <= 4'h2;
    cmd(`CMD_ATOMIC_IO, 32'h100);
    apb(1'b1, `ADDR_CMD_INDEX, 32'h50);
    chk("busy", err, 32'h1);
    for (i = 0; i < 2000 && io_lock !== 1'b0; i++) @(posedge clk_sys);
    chk("lock", io_lock, 32'h0);
    chk("n_wr", u_setup_io_partner.wr_cnt, 32'h2);
    chk("wr0", u_setup_io_partner.wr_data[0][7:0], 32'h5A);
    chk("sz", {u_setup_io_partner.wr_size[0], u_setup_io_partner.wr_size[1]},
      32'h7);
    chk("a1", u_setup_io_partner.wr_addr[1], 32'h2F);
    chk("rmw", u_setup_io_partner.wr_data[1], 32'hCAFE_1234);
    chk("rd", u_setup_io_partner.mem[74], 32'hCAFE_F00D);
    stop_test;
  end
endmodule
`default_nettype wire
